// *** design/qor_realign.sv ***
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "qor_realign_defs.svh"

// Notes on behaviour
// R1: Coarse delay applies only at realign
// R2: One-shot starts three cycles after qualification
// R3: One-shot lasts exactly three cycles
// R4: One-shot stops and restarts affected outputs
// R5: Host aligns qualifier falling edge via half-step
// R6: Host picks half-step by divide and rate
// R7: Qualify on second qualifier falling edge
// R8: Force non-exempt outputs low five cycles in
// R9: Rise after five plus delay cycles
// R10: Delay word write triggers auto realign
// R11: Host toggles pin or invert bit
// R12: Pin timing irrelevant; edge only is latched
// R13: Exempt groups never interrupted
// R14: Host keeps group two powerdown clear
// R15: Realign enable must be set
// R16: Host enables and points feedback selector
// R17: Qualify with feedback-selected group clock
// R18: Absolute mode keeps qualifier half-step fixed
// R19: Holdover mask blocks lock-loss holdover
// R20: Half-step shifts output half a cycle
// R21: Exempt qualifier keeps its delay unchanged
// R22: Half-step immediate; delay waits realign
// R23: Host holds pin over one cycle
// R24: All counts in distribution clock cycles
// R25: Synchronise realign pin before edge detect
module qor_realign #(
  parameter int GROUPS = 3,
  parameter int DW     = 8
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RST_N,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [7:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  input  wire logic              REALIGN_PIN,
  input  wire logic              FIRST_LOOP_LOCK,
  output logic      [GROUPS-1:0] GROUP_CLK,
  output logic      [GROUPS-1:0] GROUP_HALF_STEP,
  output logic                   ONE_SHOT,
  output logic                   REALIGN_BUSY,
  output logic                   HOLDOVER
);
  // ==========================================
  // Helpers
  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] qor_merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        old[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    return old;
  endfunction

  // Divide value with a floor of two
  function automatic logic [DW-1:0] qor_div(input logic [DW-1:0] d);
    return (d < DW'(2)) ? DW'(2) : d;
  endfunction

  // ==========================================
  // Reset release
  logic rst_meta;                      // First reset stage
  logic rst_n;                         // Released reset

  // Two-stage reset release
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================
  // Pin synchronisers
  logic [2:0] pin_sync;                // Realign pin stages
  logic [2:0] lock_sync;               // Lock detect stages
  logic       pin_level;               // Filtered realign pin
  logic       lock_level;              // Filtered lock detect
  logic       next_pin_level;
  logic       next_lock_level;

  // Accept a change once stages two and three agree
  always_comb begin
    next_pin_level  = (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_level;    // R25
    next_lock_level = (lock_sync[1] == lock_sync[2]) ? lock_sync[2] : lock_level;
  end

  // Shift the pins through three stages
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync   <= 3'h0;
      lock_sync  <= 3'h0;
      pin_level  <= 1'b0;
      lock_level <= 1'b0;
    end else begin
      pin_sync   <= {pin_sync[1:0], REALIGN_PIN};
      lock_sync  <= {lock_sync[1:0], FIRST_LOOP_LOCK};
      pin_level  <= next_pin_level;
      lock_level <= next_lock_level;
    end
  end

  // ==========================================
  // Register file and Wishbone slave
  qor_pkg::qor_ctrl_t          ctrl;          // Control word
  logic [GROUPS*DW-1:0]        delay_cfg;     // Pending coarse delays
  logic [GROUPS*DW-1:0]        divide_cfg;    // Divide values
  logic [15:0]                 flags;         // Half-step and exempt bits
  logic                        auto_req;      // Auto realign pulse
  qor_pkg::qor_ctrl_t          next_ctrl;
  logic [GROUPS*DW-1:0]        next_delay_cfg;
  logic [GROUPS*DW-1:0]        next_divide_cfg;
  logic [15:0]                 next_flags;
  logic                        next_auto_req;
  logic                        next_ack;
  logic [31:0]                 next_dat;
  logic [31:0]                 status;        // Live state view
  logic [31:0]                 mrg;           // Byte-merged write word
  logic                        wr_take;       // Write accepted
  logic                        abs_mode;      // Qualifier is exempt
  logic [1:0]                  fb_idx;        // Qualifier index
  logic                        hold_raw;      // Holdover request
  logic [GROUPS-1:0]           exempt;        // Realign-exempt groups
  logic [GROUPS-1:0]           held;          // Groups awaiting restart
  logic                        pending;       // Latched request
  qor_pkg::qor_state_t         state;         // Sequencer state

  assign exempt   = flags[`QOR_FLAGS_EXEMPT +: GROUPS];
  assign fb_idx   = (int'(ctrl.feedback_select) < GROUPS) ? ctrl.feedback_select : 2'h0;
  assign abs_mode = exempt[fb_idx];                                                 // R21 R18
  assign hold_raw = ~lock_level & ~ctrl.lock_loss_holdover_mask;                    // R19
  assign wr_take  = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O;
  assign status   = {21'h0, 3'(held), 1'b0, 3'(state),
                     lock_level, abs_mode, pending, REALIGN_BUSY};

  // Decode, byte merge, read mux
  always_comb begin
    next_ctrl       = ctrl;
    next_delay_cfg  = delay_cfg;
    next_divide_cfg = divide_cfg;
    next_flags      = flags;
    next_auto_req   = 1'b0;
    next_ack        = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    next_dat        = 32'h0;
    mrg             = 32'h0;
    if (wr_take) begin
      case (WB_ADR_I)
        `QOR_OFS_CTRL: begin
          mrg       = qor_merge(32'(ctrl), WB_DAT_I, WB_SEL_I);
          next_ctrl = qor_pkg::qor_ctrl_t'(mrg[`QOR_CTRL_W-1:0]);
        end
        `QOR_OFS_DELAY: begin
          mrg            = qor_merge(32'(delay_cfg), WB_DAT_I, WB_SEL_I);
          next_delay_cfg = mrg[GROUPS*DW-1:0];
          next_auto_req  = ctrl.auto_realign & ctrl.realign_enable;                 // R10
        end
        `QOR_OFS_FLAGS: begin
          mrg        = qor_merge(32'(flags), WB_DAT_I, WB_SEL_I);
          next_flags = mrg[15:0];
        end
        `QOR_OFS_DIVIDE: begin
          mrg             = qor_merge(32'(divide_cfg), WB_DAT_I, WB_SEL_I);
          next_divide_cfg = mrg[GROUPS*DW-1:0];
        end
        default: ;       // Unmapped or read-only: ignored
      endcase
    end
    if (next_ack && !WB_WE_I) begin
      case (WB_ADR_I)
        `QOR_OFS_CTRL:   next_dat = 32'(ctrl);
        `QOR_OFS_DELAY:  next_dat = 32'(delay_cfg);
        `QOR_OFS_FLAGS:  next_dat = 32'(flags);
        `QOR_OFS_DIVIDE: next_dat = 32'(divide_cfg);
        `QOR_OFS_STATUS: next_dat = status;
        default:         next_dat = 32'h0;
      endcase
    end
  end

  // Register file state
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ctrl       <= qor_pkg::qor_ctrl_t'(`QOR_CTRL_RESET);
      delay_cfg  <= `QOR_DELAY_RESET;
      divide_cfg <= `QOR_DIVIDE_RESET;
      flags      <= `QOR_FLAGS_RESET;
      auto_req   <= 1'b0;
      WB_ACK_O   <= 1'b0;
      WB_DAT_O   <= 32'h0;
      HOLDOVER   <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      delay_cfg  <= next_delay_cfg;
      divide_cfg <= next_divide_cfg;
      flags      <= next_flags;
      auto_req   <= next_auto_req;
      WB_ACK_O   <= next_ack;
      WB_DAT_O   <= next_dat;
      HOLDOVER   <= hold_raw;
    end
  end

  // ==========================================
  // Realign sequencer
  logic [GROUPS-1:0][DW-1:0] active_dly;      // Delays in force
  logic [GROUPS-1:0]         clk_int;         // Raw divider outputs
  logic [GROUPS-1:0]         rel;             // Restart this cycle
  logic [1:0]                edges;           // Qualifier falls seen
  logic [3:0]                cnt;             // Lead and pulse count
  logic [9:0]                post;            // Cycles since pulse end
  logic                      level_prev;      // Previous request level
  logic                      qual_prev;       // Previous qualifier level
  logic                      force_on;        // Outputs forced low
  logic                      level;           // Request level
  logic                      req;             // New request
  qor_pkg::qor_state_t       next_state;
  logic [GROUPS-1:0][DW-1:0] next_active_dly;
  logic [GROUPS-1:0]         next_held;
  logic [1:0]                next_edges;
  logic [3:0]                next_cnt;
  logic [9:0]                next_post;
  logic                      next_pending;

  assign level    = pin_level ^ ctrl.realign_polarity_invert;                       // R12
  assign req      = ((level & ~level_prev) | auto_req) & ctrl.realign_enable;
  assign force_on = (state == qor_pkg::QOR_RESTART) &&
                    (post >= 10'(`QOR_FORCE_CYC - `QOR_PULSE_CYC - 1));             // R8

  // Restart point per group
  always_comb begin
    for (int g = 0; g < GROUPS; g++) begin
      rel[g] = held[g] && (state == qor_pkg::QOR_RESTART) &&
               (post == 10'(active_dly[g]) + 10'(`QOR_RISE_CYC));                   // R9
    end
  end

  // Next state of the sequencer
  always_comb begin
    next_state      = state;
    next_active_dly = active_dly;
    next_held       = held;
    next_edges      = edges;
    next_cnt        = cnt;
    next_post       = post;
    next_pending    = pending | req;
    case (state)
      qor_pkg::QOR_IDLE: begin
        if (pending) begin
          next_pending = req;
          next_edges   = 2'h0;
          next_cnt     = 4'h0;
          next_state   = ctrl.output_qualified_realign ? qor_pkg::QOR_QUALIFY : qor_pkg::QOR_LEAD;
        end
      end
      qor_pkg::QOR_QUALIFY: begin
        if (qual_prev && !clk_int[fb_idx]) begin                                    // R17
          if (edges == 2'(`QOR_QUAL_EDGES - 1)) begin
            next_state = qor_pkg::QOR_LEAD;                                         // R7
          end else begin
            next_edges = edges + 2'h1;
          end
        end
      end
      qor_pkg::QOR_LEAD: begin
        if (cnt >= 4'(`QOR_QUAL_DELAY - 2)) begin
          next_cnt   = 4'h0;
          next_state = qor_pkg::QOR_PULSE;                                          // R2
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      qor_pkg::QOR_PULSE: begin
        if (cnt == 4'(`QOR_PULSE_CYC - 1)) begin                                    // R3
          next_post  = 10'h0;
          next_held  = ~exempt;                                                     // R13 R4
          next_state = qor_pkg::QOR_RESTART;
          for (int g = 0; g < GROUPS; g++) begin
            if (!exempt[g]) begin
              next_active_dly[g] = delay_cfg[g*DW +: DW];                           // R1 R22
            end
          end
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      qor_pkg::QOR_RESTART: begin
        next_post = post + 10'h1;                                                   // R24
        next_held = held & ~rel;
        if (next_held == '0) begin
          next_state = qor_pkg::QOR_IDLE;
        end
      end
      default: next_state = qor_pkg::QOR_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state        <= qor_pkg::QOR_IDLE;
      active_dly   <= `QOR_DELAY_RESET;
      held         <= '0;
      edges        <= 2'h0;
      cnt          <= 4'h0;
      post         <= 10'h0;
      pending      <= 1'b0;
      level_prev   <= 1'b0;
      qual_prev    <= 1'b0;
      ONE_SHOT     <= 1'b0;
      REALIGN_BUSY <= 1'b0;
    end else begin
      state        <= next_state;
      active_dly   <= next_active_dly;
      held         <= next_held;
      edges        <= next_edges;
      cnt          <= next_cnt;
      post         <= next_post;
      pending      <= next_pending;
      level_prev   <= level;
      qual_prev    <= clk_int[fb_idx];
      ONE_SHOT     <= (next_state == qor_pkg::QOR_PULSE);
      REALIGN_BUSY <= (next_state != qor_pkg::QOR_IDLE);
    end
  end

  // ==========================================
  // Output group dividers
  for (genvar g = 0; g < GROUPS; g++) begin : gen_group
    logic [DW-1:0] div_cnt;            // Position in period
    logic [DW-1:0] next_div_cnt;
    logic [DW-1:0] deff;               // Effective divide
    logic          next_clk_int;
    logic          next_clk_o;
    logic          pd;                 // Drivers off

    assign deff = qor_div(divide_cfg[g*DW +: DW]);
    assign pd   = (g == 2) ? ctrl.group2_powerdown : 1'b0;

    // Count the period, restart on release
    always_comb begin
      next_div_cnt = (div_cnt >= deff - DW'(1)) ? DW'(0) : div_cnt + DW'(1);
      if (rel[g]) begin
        next_div_cnt = DW'(0);
      end
      next_clk_int = next_div_cnt < (deff - (deff >> 1));
      next_clk_o   = next_clk_int & ~(held[g] & ~rel[g] & force_on) & ~pd;          // R4
    end

    // Divider registers and half-step output
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
        div_cnt            <= DW'(0);
        clk_int[g]         <= 1'b0;
        GROUP_CLK[g]       <= 1'b0;
        GROUP_HALF_STEP[g] <= 1'b0;
      end else begin
        div_cnt            <= next_div_cnt;
        clk_int[g]         <= next_clk_int;
        GROUP_CLK[g]       <= next_clk_o;
        GROUP_HALF_STEP[g] <= flags[g];                                             // R20 R22
      end
    end
  end
endmodule

// *** design/qor_realign_defs.svh ***
`ifndef QOR_REALIGN_DEFS_SVH
`define QOR_REALIGN_DEFS_SVH
// ==========================================
// Register byte offsets
`define QOR_OFS_CTRL      8'h00
`define QOR_OFS_DELAY     8'h04
`define QOR_OFS_FLAGS     8'h08
`define QOR_OFS_DIVIDE    8'h0C
`define QOR_OFS_STATUS    8'h10
// ==========================================
// Control field positions and reset values
`define QOR_CTRL_W        8
`define QOR_CTRL_RESET    8'h01
`define QOR_DELAY_RESET   24'h050505
`define QOR_DIVIDE_RESET  24'h040404
`define QOR_FLAGS_RESET   16'h0000
`define QOR_FLAGS_EXEMPT  8
// ==========================================
// Realign timing in distribution cycles
`define QOR_QUAL_EDGES    2
`define QOR_QUAL_DELAY    3
`define QOR_PULSE_CYC     3
`define QOR_FORCE_CYC     5
`define QOR_RISE_CYC      5
`endif

// *** design/qor_pkg.sv ***
package qor_pkg;
  // ==========================================
  // Sequencer states
  typedef enum logic [2:0] {
    QOR_IDLE,
    QOR_QUALIFY,
    QOR_LEAD,
    QOR_PULSE,
    QOR_RESTART
  } qor_state_t;

  // ==========================================
  // Control word, bit 0 first from the right
  typedef struct packed {
    logic       group2_powerdown;
    logic [1:0] feedback_select;
    logic       lock_loss_holdover_mask;
    logic       auto_realign;
    logic       realign_polarity_invert;
    logic       output_qualified_realign;
    logic       realign_enable;
  } qor_ctrl_t;
endpackage

// *** test/qor_realign_monitor.sv ***
`timescale 1ns/1ps
`include "qor_realign_defs.svh"
// ==========================================
// Realign checker on the top ports
module qor_realign_monitor #(
  parameter int GROUPS = 3
) (
  input wire logic              CLK_SYS,
  input wire logic              RST_N,
  input wire logic              WB_CYC_I,
  input wire logic              WB_STB_I,
  input wire logic              WB_WE_I,
  input wire logic [7:0]        WB_ADR_I,
  input wire logic [3:0]        WB_SEL_I,
  input wire logic [31:0]       WB_DAT_I,
  input wire logic [31:0]       WB_DAT_O,
  input wire logic              WB_ACK_O,
  input wire logic              REALIGN_PIN,
  input wire logic              FIRST_LOOP_LOCK,
  input wire logic [GROUPS-1:0] GROUP_CLK,
  input wire logic [GROUPS-1:0] GROUP_HALF_STEP,
  input wire logic              ONE_SHOT,
  input wire logic              REALIGN_BUSY,
  input wire logic              HOLDOVER
);
  logic              wr;          // Write taken this edge
  logic [GROUPS-1:0] exempt;      // Exempt groups mirror
  logic [GROUPS-1:0] hs;          // Half-step mirror
  logic              mask;        // Holdover mask mirror
  logic [GROUPS-1:0] next_exempt;
  logic [GROUPS-1:0] next_hs;
  logic              next_mask;
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O;
  // ==========================================
  // Mirror of the written control bits
  always_comb begin
    next_exempt = exempt;
    next_hs = hs;
    next_mask = mask;
    if (wr && WB_ADR_I == `QOR_OFS_FLAGS && WB_SEL_I[0]) next_hs = WB_DAT_I[GROUPS-1:0];
    if (wr && WB_ADR_I == `QOR_OFS_FLAGS && WB_SEL_I[1]) next_exempt = WB_DAT_I[8 +: GROUPS];
    if (wr && WB_ADR_I == `QOR_OFS_CTRL && WB_SEL_I[0]) next_mask = WB_DAT_I[4];
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      exempt <= '0;
      hs <= '0;
      mask <= 1'h0;
    end else begin
      exempt <= next_exempt;
      hs <= next_hs;
      mask <= next_mask;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // ==========================================
  // Properties
  property p_ack; (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
  property p_width; $rose(ONE_SHOT) |-> ONE_SHOT[*3] ##1 !ONE_SHOT; endproperty
  property p_lead; $rose(ONE_SHOT) |-> $past(REALIGN_BUSY, 2); endproperty
  property p_busy; ONE_SHOT |-> REALIGN_BUSY; endproperty
  property p_force; $rose(ONE_SHOT) |-> ##5 ((GROUP_CLK & ~exempt) == '0); endproperty
  property p_gap; $fell(ONE_SHOT) |-> ##2 ((GROUP_CLK & ~exempt) == '0)[*3]; endproperty
  property p_half; GROUP_HALF_STEP == $past(hs); endproperty
  property p_mask; (mask && $past(mask)) |-> !HOLDOVER; endproperty
  property p_hold; (!FIRST_LOOP_LOCK && !mask)[*8] |-> HOLDOVER; endproperty
  a_ack:   assert property (p_ack) else $error("bus ack not single cycle");
  a_width: assert property (p_width) else $error("one-shot width wrong");
  a_lead:  assert property (p_lead) else $error("one-shot without prior busy");
  a_busy:  assert property (p_busy) else $error("one-shot outside busy");
  a_force: assert property (p_force) else $error("outputs not forced low");
  a_gap:   assert property (p_gap) else $error("output rose too early");
  a_half:  assert property (p_half) else $error("half-step flag lagging");
  a_mask:  assert property (p_mask) else $error("holdover despite mask");
  a_hold:  assert property (p_hold) else $error("no holdover on lock loss");
  c_shot:  cover property ($rose(ONE_SHOT));
  c_hold:  cover property ($rose(HOLDOVER));
  c_half:  cover property (GROUP_HALF_STEP != '0);
endmodule

// *** test/qor_host_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Host: register bus master and realign pin
module qor_host_model (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      wdat,
  output logic             pin
);
  int timeouts; // Unanswered bus cycles
  initial begin
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    pin = 1'h0;
    timeouts = 0;
  end
  // One classic cycle, held until ack or 64 cycles
  task automatic cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 64);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (n >= 64) timeouts++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    cycle(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    cycle(1'h0, a, 32'h0, q);
  endtask
  // Pin held well over one cycle
  task automatic pin_pulse;
    @(posedge clk);
    pin <= 1'h1;
    repeat (6) @(posedge clk);
    pin <= 1'h0;
  endtask
endmodule

// *** test/qor_realign_tb.sv ***
`timescale 1ns/1ps
`include "qor_realign_defs.svh"
// ==========================================
// Realign testbench
module qor_realign_tb;
  logic        clk, rst_n, lock, cyc, stb, we, pin, ack, shot, busy, hold;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic [2:0]  gclk, ghs;
  int          fail_count, checked, os_at, os_len, rise1, rise2, ex_tog;
  qor_host_model host (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
                       .sel(sel), .wdat(wdat), .pin(pin));
  qor_realign DUT (.CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
                   .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
                   .REALIGN_PIN(pin), .FIRST_LOOP_LOCK(lock), .GROUP_CLK(gclk), .GROUP_HALF_STEP(ghs),
                   .ONE_SHOT(shot), .REALIGN_BUSY(busy), .HOLDOVER(hold));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Watch pulse, restart order and exempt toggling
  task automatic observe(input int n);
    logic       pos, fell;
    logic [2:0] pg;
    os_at = -1;
    os_len = 0;
    rise1 = -1;
    rise2 = -1;
    ex_tog = 0;
    fell = 1'h0;
    pos = 1'h0;
    pg = gclk;
    for (int t = 0; t < n; t++) begin
      @(negedge clk);
      if (shot === 1'h1 && !pos && os_at < 0) os_at = t;
      if (shot === 1'h1) os_len++;
      if (shot === 1'h0 && pos) fell = 1'h1;
      if (busy === 1'h1 && gclk[0] !== pg[0]) ex_tog++;
      // Only restarts count: skip toggles before the forced-low window
      if (fell && os_at >= 0 && t > os_at + 8 && gclk[1] === 1'h1 && !pg[1] && rise1 < 0) rise1 = t;
      if (fell && os_at >= 0 && t > os_at + 8 && gclk[2] === 1'h1 && !pg[2] && rise2 < 0) rise2 = t;
      pos = shot;
      pg = gclk;
    end
  endtask
  task automatic close_out;
    fail_count += host.timeouts;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    close_out;
  end
  initial begin
    rst_n = 1'h0;
    lock = 1'h1;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    host.rd(`QOR_OFS_CTRL, rd); check(rd, {24'h0, `QOR_CTRL_RESET});
    host.rd(`QOR_OFS_DELAY, rd); check(rd, {8'h0, `QOR_DELAY_RESET});
    host.rd(8'h20, rd); check(rd, 32'h0);
    // Group0 exempt, group2 half step takes effect at once
    host.wr(`QOR_OFS_FLAGS, 32'h104);
    repeat (2) @(negedge clk);
    check({29'h0, ghs}, 32'h4);
    // Qualified on group1, enabled, group2 powered
    host.wr(`QOR_OFS_CTRL, 32'h23);
    host.wr(`QOR_OFS_DELAY, 32'h0A0505);
    observe(60); check(os_len, 0);
    fork
      host.pin_pulse;
      observe(200);
    join
    check(os_len, 3);
    check(rise2 - rise1, 5);
    check(ex_tog > 0, 1);
    // Polarity invert flip alone requests
    host.wr(`QOR_OFS_CTRL, 32'h27);
    observe(200); check(os_len, 3);
    host.wr(`QOR_OFS_CTRL, 32'h23);
    // Auto realign on delay word write
    host.wr(`QOR_OFS_CTRL, 32'h2B);
    host.wr(`QOR_OFS_DELAY, 32'h050A05);
    observe(200); check(os_len, 3);
    check(rise1 - rise2, 5);
    // Function disabled: pin ignored
    host.wr(`QOR_OFS_CTRL, 32'h22);
    fork
      host.pin_pulse;
      observe(150);
    join
    check(os_len, 0);
    // Lock loss with and without mask
    lock <= 1'h0;
    repeat (10) @(negedge clk);
    check(hold, 1);
    host.wr(`QOR_OFS_CTRL, 32'h33);
    repeat (3) @(negedge clk);
    check(hold, 0);
    lock <= 1'h1;
    close_out;
  end
endmodule
bind qor_realign qor_realign_monitor #(.GROUPS(GROUPS)) u_mon (.*);
